// ===== csil_pkg.sv
package csil_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, data-memory addresses
  localparam logic [7:0] CSIL_FLAGS_ADDR  = 8'h0a;
  localparam logic [7:0] CSIL_IRQ_ADDR    = 8'h0b;

  // core_flags field positions
  localparam int unsigned CSIL_C_BIT      = 0;
  localparam int unsigned CSIL_HALF_BIT   = 1;
  localparam int unsigned CSIL_Z_BIT      = 2;
  localparam int unsigned CSIL_WRAP_BIT   = 3;
  localparam int unsigned CSIL_SLEEP_BIT  = 4;
  localparam int unsigned CSIL_WDOG_BIT   = 5;

  // irq_control field positions
  localparam int unsigned CSIL_GIE_BIT    = 0;
  localparam int unsigned CSIL_EXT_EN_BIT = 1;
  localparam int unsigned CSIL_TA_EN_BIT  = 2;
  localparam int unsigned CSIL_TB_EN_BIT  = 3;
  localparam int unsigned CSIL_EXT_PD_BIT = 4;
  localparam int unsigned CSIL_TA_PD_BIT  = 5;
  localparam int unsigned CSIL_TB_PD_BIT  = 6;

  // reset values
  localparam logic [5:0] CSIL_FLAGS_RST   = 6'h00;
  localparam logic [6:0] CSIL_IRQ_RST     = 7'h00;

  // fixed service entry points
  localparam logic [7:0] CSIL_VEC_EXT     = 8'h04;
  localparam logic [7:0] CSIL_VEC_TA      = 8'h08;
  localparam logic [7:0] CSIL_VEC_TB      = 8'h0c;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    CSIL_OP_ADD  = 4'h0,
    CSIL_OP_ADC  = 4'h1,
    CSIL_OP_SUB  = 4'h2,
    CSIL_OP_SBC  = 4'h3,
    CSIL_OP_AND  = 4'h4,
    CSIL_OP_OR   = 4'h5,
    CSIL_OP_XOR  = 4'h6,
    CSIL_OP_CPL  = 4'h7,
    CSIL_OP_INC  = 4'h8,
    CSIL_OP_DEC  = 4'h9,
    CSIL_OP_RL   = 4'ha,
    CSIL_OP_RR   = 4'hb,
    CSIL_OP_RLC  = 4'hc,
    CSIL_OP_RRC  = 4'hd,
    CSIL_OP_DAA  = 4'he
  } csil_alu_op_e;

  typedef enum logic {
    CSIL_RUN   = 1'b0,
    CSIL_ENTRY = 1'b1
  } csil_seq_e;

  typedef struct packed {
    csil_alu_op_e op;
    logic [7:0]   a;
    logic [7:0]   b;
  } csil_alu_req_s;

  typedef struct packed {
    logic [7:0] data;
    logic       skip;
  } csil_alu_rsp_s;

endpackage

// ===== csil_core_status_irq.sv
`timescale 1ns/100ps
module csil_core_status_irq
  import csil_pkg::*;
(
  input  wire logic          clk,                  // system clock, 125 MHz
  input  wire logic          rst,                  // async reset, active high
  input  wire logic [7:0]    addr,                 // register address
  input  wire logic [7:0]    wdata,                // register write data
  input  wire logic          wr,                   // write strobe
  input  wire logic          rd,                   // read strobe
  output logic      [7:0]    rdata,                // read data, cycle after rd
  input  wire logic          alu_valid,            // alu request strobe
  input  wire csil_alu_req_s alu_req,              // op and operands
  output logic               alu_rsp_valid,        // result strobe
  output csil_alu_rsp_s      alu_rsp,              // result and skip decision
  input  wire logic          sleep_instr,          // sleep executed
  input  wire logic          watchdog_clear_instr, // watchdog clear executed
  input  wire logic          watchdog_timeout,     // watchdog timed out
  input  wire logic          irq_exit_instr,       // interrupt return executed
  input  wire logic          ext_irq_pin,          // external pin, async
  input  wire logic          timer_a_ovf,          // timer a overflow pulse
  input  wire logic          timer_b_ovf,          // timer b overflow pulse
  input  wire logic          stack_full,           // stack holds no free level
  input  wire logic          instr_boundary,       // current instruction done
  output logic               irq_ack,              // push pc and branch
  output logic      [7:0]    irq_vector,           // branch target
  output logic               wake_req,             // leave sleep
  output logic      [5:0]    flags_view            // live status flags
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [5:0]    core_flags;
  logic [6:0]    irq_control;
  logic [5:0]    next_core_flags;
  logic [6:0]    next_irq_control;
  csil_seq_e     seq;
  csil_seq_e     next_seq;
  logic          ext_s1;
  logic          ext_s2;
  logic          ext_s3;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire sel_flags = (addr == CSIL_FLAGS_ADDR);
  wire sel_irq   = (addr == CSIL_IRQ_ADDR);
  wire wr_flags  = wr && sel_flags;
  wire wr_irq    = wr && sel_irq;

  ////////////////////////////////////////////////////////////////////////////
  // alu operand shaping; subtract is add of inverted operand
  wire       flag_c  = core_flags[CSIL_C_BIT];
  wire       flag_h  = core_flags[CSIL_HALF_BIT];
  wire       is_sub  = (alu_req.op == CSIL_OP_SUB) || (alu_req.op == CSIL_OP_SBC);
  wire       use_c   = (alu_req.op == CSIL_OP_ADC) || (alu_req.op == CSIL_OP_SBC);
  wire [7:0] b_eff   = is_sub ? ~alu_req.b : alu_req.b;
  wire       cin     = use_c ? flag_c : is_sub;

  // carries: full, low nibble, into msb
  wire [8:0] sum_full = {1'b0, alu_req.a} + {1'b0, b_eff} + {8'h00, cin};
  wire [4:0] sum_lo   = {1'b0, alu_req.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  wire [7:0] sum_l7   = {1'b0, alu_req.a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, cin};
  wire       arith_ov = sum_l7[7] ^ sum_full[8];

  // decimal adjust after a bcd addition
  wire       daa_lo  = (alu_req.a[3:0] > 4'h9) || flag_h;
  wire [8:0] daa_mid = {1'b0, alu_req.a} + (daa_lo ? 9'h006 : 9'h000);
  wire       daa_hi  = daa_mid[8] || (daa_mid[7:4] > 4'h9) || flag_c;
  wire [8:0] daa_sum = daa_mid + (daa_hi ? 9'h060 : 9'h000);

  ////////////////////////////////////////////////////////////////////////////
  // alu result and which flags the op touches
  logic [7:0] alu_data;
  logic       upd_arith;
  logic       upd_z;
  logic       upd_c;
  logic       new_c;

  always_comb begin
    alu_data  = alu_req.a;
    upd_arith = 1'b0;
    upd_z     = 1'b0;
    upd_c     = 1'b0;
    new_c     = flag_c;
    unique case (alu_req.op)
      CSIL_OP_ADD, CSIL_OP_ADC, CSIL_OP_SUB, CSIL_OP_SBC: begin
        alu_data  = sum_full[7:0];
        upd_arith = 1'b1;
      end
      CSIL_OP_AND: begin
        alu_data = alu_req.a & alu_req.b;
        upd_z    = 1'b1;
      end
      CSIL_OP_OR: begin
        alu_data = alu_req.a | alu_req.b;
        upd_z    = 1'b1;
      end
      CSIL_OP_XOR: begin
        alu_data = alu_req.a ^ alu_req.b;
        upd_z    = 1'b1;
      end
      CSIL_OP_CPL: begin
        alu_data = ~alu_req.a;
        upd_z    = 1'b1;
      end
      CSIL_OP_INC: begin
        alu_data = alu_req.a + 8'h01;
        upd_z    = 1'b1;
      end
      CSIL_OP_DEC: begin
        alu_data = alu_req.a - 8'h01;
        upd_z    = 1'b1;
      end
      CSIL_OP_RL: begin
        alu_data = {alu_req.a[6:0], alu_req.a[7]};
      end
      CSIL_OP_RR: begin
        alu_data = {alu_req.a[0], alu_req.a[7:1]};
      end
      CSIL_OP_RLC: begin
        alu_data = {alu_req.a[6:0], flag_c};
        upd_c    = 1'b1;
        new_c    = alu_req.a[7];
      end
      CSIL_OP_RRC: begin
        alu_data = {flag_c, alu_req.a[7:1]};
        upd_c    = 1'b1;
        new_c    = alu_req.a[0];
      end
      CSIL_OP_DAA: begin
        alu_data = daa_sum[7:0];
        upd_c    = 1'b1;
        new_c    = daa_hi || daa_sum[8];
      end
      default: begin
        alu_data = alu_req.a;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next flags: software write, then alu, then sleep and watchdog events
  always_comb begin
    next_core_flags = core_flags;
    if (wr_flags) begin
      next_core_flags[CSIL_WRAP_BIT:CSIL_C_BIT] = wdata[CSIL_WRAP_BIT:CSIL_C_BIT];
    end
    if (alu_valid && upd_arith) begin
      next_core_flags[CSIL_C_BIT]    = sum_full[8];
      next_core_flags[CSIL_HALF_BIT] = sum_lo[4];
      next_core_flags[CSIL_WRAP_BIT] = arith_ov;
    end
    if (alu_valid && (upd_arith || upd_z)) begin
      next_core_flags[CSIL_Z_BIT] = (alu_data == 8'h00);
    end
    if (alu_valid && upd_c) begin
      next_core_flags[CSIL_C_BIT] = new_c;
    end
    // sleep wins over a watchdog clear in the same cycle
    if (sleep_instr) begin
      next_core_flags[CSIL_SLEEP_BIT] = 1'b1;
    end else if (watchdog_clear_instr) begin
      next_core_flags[CSIL_SLEEP_BIT] = 1'b0;
    end
    // a timeout is never lost to a simultaneous clear
    if (watchdog_timeout) begin
      next_core_flags[CSIL_WDOG_BIT] = 1'b1;
    end else if (watchdog_clear_instr || sleep_instr) begin
      next_core_flags[CSIL_WDOG_BIT] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external pin synchroniser and falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1 <= 1'b1;
      ext_s2 <= 1'b1;
      ext_s3 <= 1'b1;
    end else begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  wire ext_fall = ext_s3 && !ext_s2;

  ////////////////////////////////////////////////////////////////////////////
  // request qualification, fixed priority
  wire gie     = irq_control[CSIL_GIE_BIT];
  wire req_ext = irq_control[CSIL_EXT_PD_BIT] && irq_control[CSIL_EXT_EN_BIT];
  wire req_ta  = irq_control[CSIL_TA_PD_BIT] && irq_control[CSIL_TA_EN_BIT];
  wire req_tb  = irq_control[CSIL_TB_PD_BIT] && irq_control[CSIL_TB_EN_BIT];
  wire any_req = req_ext || req_ta || req_tb;
  // stack full holds the request back until a return frees a level
  wire take    = (seq == CSIL_RUN) && instr_boundary && gie
                 && !stack_full && any_req;
  wire take_ext = take && req_ext;
  wire take_ta  = take && !req_ext && req_ta;
  wire take_tb  = take && !req_ext && !req_ta;
  wire [7:0] take_vec = req_ext ? CSIL_VEC_EXT :
                        req_ta  ? CSIL_VEC_TA  : CSIL_VEC_TB;

  ////////////////////////////////////////////////////////////////////////////
  // next irq_control: write, exit, entry clear, then hardware sets win last
  always_comb begin
    next_irq_control = irq_control;
    if (wr_irq) begin
      next_irq_control = wdata[6:0];
    end
    if (irq_exit_instr) begin
      next_irq_control[CSIL_GIE_BIT] = 1'b1;
    end
    if (take) begin
      next_irq_control[CSIL_GIE_BIT] = 1'b0;
    end
    if (take_ext) begin
      next_irq_control[CSIL_EXT_PD_BIT] = 1'b0;
    end
    if (take_ta) begin
      next_irq_control[CSIL_TA_PD_BIT] = 1'b0;
    end
    if (take_tb) begin
      next_irq_control[CSIL_TB_PD_BIT] = 1'b0;
    end
    if (ext_fall) begin
      next_irq_control[CSIL_EXT_PD_BIT] = 1'b1;
    end
    if (timer_a_ovf) begin
      next_irq_control[CSIL_TA_PD_BIT] = 1'b1;
    end
    if (timer_b_ovf) begin
      next_irq_control[CSIL_TB_PD_BIT] = 1'b1;
    end
  end

  assign next_seq = take ? CSIL_ENTRY : CSIL_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_flags  <= CSIL_FLAGS_RST;
      irq_control <= CSIL_IRQ_RST;
      seq         <= CSIL_RUN;
      irq_vector  <= 8'h00;
    end else begin
      core_flags  <= next_core_flags;
      irq_control <= next_irq_control;
      seq         <= next_seq;
      irq_vector  <= take ? take_vec : irq_vector;
    end
  end

  // alu result register, skip decision is a zero test of the result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alu_rsp_valid <= 1'b0;
      alu_rsp       <= '0;
    end else begin
      alu_rsp_valid <= alu_valid;
      alu_rsp       <= alu_valid ? {alu_data, (alu_data == 8'h00)} : alu_rsp;
    end
  end

  // read port; unmapped addresses and idle cycles give zero
  wire [7:0] rd_mux = sel_flags ? {2'b00, core_flags} :
                      sel_irq   ? {1'b0, irq_control} : 8'h00;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; only the pc is pushed, flags stay with software
  assign irq_ack    = (seq == CSIL_ENTRY);
  // any pending source wakes, even with enables low
  assign wake_req   = irq_control[CSIL_EXT_PD_BIT] || irq_control[CSIL_TA_PD_BIT]
                      || irq_control[CSIL_TB_PD_BIT];
  assign flags_view = core_flags;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire [8:0] chk_add = {1'b0, alu_req.a} + {1'b0, alu_req.b};

  AST_FLAGS_TOP_ZERO: assert property (rd && sel_flags |=> rdata[7:6] == 2'b00)
    else $error("flags top bits not zero");
  AST_WR_KEEPS_SLEEP_WDOG: assert property (
    wr_flags && !sleep_instr && !watchdog_clear_instr && !watchdog_timeout
      |=> $stable(core_flags[CSIL_WDOG_BIT:CSIL_SLEEP_BIT]))
    else $error("flags write disturbed sleep or timeout flag");
  AST_ADD_CARRY: assert property (
    alu_valid && alu_req.op == CSIL_OP_ADD |=> core_flags[CSIL_C_BIT] == $past(chk_add[8]))
    else $error("add carry wrong");
  AST_AND_ZERO: assert property (
    alu_valid && alu_req.op == CSIL_OP_AND && (alu_req.a & alu_req.b) == 8'h00
      |=> core_flags[CSIL_Z_BIT] && alu_rsp.skip)
    else $error("zero flag not set");
  AST_SLEEP_FLAGS: assert property (
    sleep_instr && !watchdog_timeout
      |=> core_flags[CSIL_SLEEP_BIT] && !core_flags[CSIL_WDOG_BIT])
    else $error("sleep flags wrong");
  AST_TIMEOUT_SET: assert property (watchdog_timeout |=> core_flags[CSIL_WDOG_BIT])
    else $error("timeout flag lost");
  AST_FULL_BLOCKS: assert property (stack_full |=> !irq_ack)
    else $error("ack while stack full");
  AST_ENTRY_GIE_LOW: assert property (irq_ack |-> !gie)
    else $error("global enable still set on entry");
  AST_EXT_ENTRY: assert property (
    (seq == CSIL_RUN) && instr_boundary && gie && !stack_full && req_ext
      |=> irq_ack && irq_vector == CSIL_VEC_EXT)
    else $error("external entry wrong");
  AST_TA_SETS: assert property (
    timer_a_ovf |=> irq_control[CSIL_TA_PD_BIT] ##1 wake_req or irq_control[CSIL_TA_PD_BIT])
    else $error("timer a pending lost");
  AST_EXIT_GIE: assert property (irq_exit_instr && !take |=> gie)
    else $error("exit did not set global enable");
  AST_ONE_CYCLE_ACK: assert property (irq_ack |=> !irq_ack)
    else $error("ack longer than one cycle");

  COV_EXT: cover property (irq_ack && irq_vector == CSIL_VEC_EXT);
  COV_TA: cover property (irq_ack && irq_vector == CSIL_VEC_TA);
  COV_TB: cover property (irq_ack && irq_vector == CSIL_VEC_TB);
  COV_FULL_THEN_ACK: cover property (stack_full && any_req && gie ##1 !stack_full ##[1:8] irq_ack);

endmodule

// ===== csil_seq_model.sv
`timescale 1ns/100ps
// far side: sequencer marking instruction ends, plus an eight-level pc stack
module csil_seq_model (
  input  wire logic       clk,            // system clock
  input  wire logic       rst,            // async reset, active high
  input  wire logic [1:0] gap,            // idle cycles between boundaries
  input  wire logic       irq_ack,        // acknowledge from the block
  input  wire logic       push,           // subroutine call
  input  wire logic       pop,            // any return
  output logic            instr_boundary, // current instruction done
  output logic            stack_full      // no free stack level
);
  logic [1:0] cnt;
  logic [3:0] depth;
  logic       do_push;

  ////////////////////////////////////////////////////////////////////////
  // only the pc goes on the stack; flags are left to software
  assign do_push    = irq_ack | push;
  assign stack_full = (depth == 4'h8);

  // a slow gap keeps requests waiting for the instruction end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt            <= 2'h0;
      instr_boundary <= 1'b0;
    end else begin
      cnt            <= (cnt >= gap) ? 2'h0 : cnt + 2'h1;
      instr_boundary <= (cnt >= gap);
    end
  end

  // depth saturates: a call on a full stack leaves the depth at eight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) depth <= 4'h0;
    else if (do_push && !pop && depth != 4'h8) depth <= depth + 4'h1;
    else if (pop && !do_push && depth != 4'h0) depth <= depth - 4'h1;
  end
endmodule

// ===== csil_core_status_irq_bench.sv
`timescale 1ns/100ps
`define CHK(got, want) begin compares++; if ((got) !== (want)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (got), (want)); end end
module csil_core_status_irq_bench
  import csil_pkg::*;
;
  logic          clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, alu_valid = 1'b0;
  logic          ext_pin = 1'b1, rd_q = 1'b0, bnd_q = 1'b0;
  logic [7:0]    addr = 8'h00, wdata = 8'h00, evs = 8'h00, rdata, irq_vector, e8;
  logic [1:0]    gap = 2'h0;
  csil_alu_req_s alu_req = '0;
  csil_alu_rsp_s alu_rsp;
  logic          alu_rsp_valid, irq_ack, wake_req, instr_boundary, stack_full;
  logic [5:0]    flags_view, fl;
  logic [14:0]   e15;
  logic [31:0]   seed = 32'h0000_0059;
  logic [7:0]    rq[$], iq[$];
  logic [14:0]   aq[$];
  int            num_errors = 0, compares = 0;

  always #4 clk = ~clk;

  csil_core_status_irq csil_core_status_irq_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .alu_valid(alu_valid), .alu_req(alu_req), .alu_rsp_valid(alu_rsp_valid),
    .alu_rsp(alu_rsp), .sleep_instr(evs[0]), .watchdog_clear_instr(evs[1]),
    .watchdog_timeout(evs[2]), .irq_exit_instr(evs[3]), .ext_irq_pin(ext_pin),
    .timer_a_ovf(evs[4]), .timer_b_ovf(evs[5]), .stack_full(stack_full),
    .instr_boundary(instr_boundary), .irq_ack(irq_ack), .irq_vector(irq_vector),
    .wake_req(wake_req), .flags_view(flags_view));

  csil_seq_model csil_seq_model_i (
    .clk(clk), .rst(rst), .gap(gap), .irq_ack(irq_ack), .push(evs[6]),
    .pop(evs[3] | evs[7]), .instr_boundary(instr_boundary), .stack_full(stack_full));

  ////////////////////////////////////////////////////////////////////////
  // expected values
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // returns {result, skip, flags}; subtract is a + ~b + carry-in
  function automatic logic [14:0] alu_exp(input logic [3:0] op, input logic [7:0] a,
                                          input logic [7:0] b, input logic [5:0] f);
    logic [8:0] s, t;
    logic [7:0] bb, r, h7;
    logic [4:0] h4;
    logic       ci, hi;
    logic [5:0] n;
    n  = f;
    bb = op[1] ? ~b : b;
    ci = op[0] ? f[0] : op[1];
    s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    h7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
    h4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    case (op)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        r      = s[7:0];
        n[3:0] = {h7[7] ^ s[8], r == 8'h00, h4[4], s[8]};
      end
      4'h4: r = a & b;
      4'h5: r = a | b;
      4'h6: r = a ^ b;
      4'h7: r = ~a;
      4'h8: r = a + 8'h01;
      4'h9: r = a - 8'h01;
      4'ha: r = {a[6:0], a[7]};
      4'hb: r = {a[0], a[7:1]};
      4'hc: begin
        r    = {a[6:0], f[0]};
        n[0] = a[7];
      end
      4'hd: begin
        r    = {f[0], a[7:1]};
        n[0] = a[0];
      end
      // decimal adjust: add six to a digit above nine or one that carried
      4'he: begin
        t    = {1'b0, a} + (((a[3:0] > 4'h9) || f[1]) ? 9'h006 : 9'h000);
        hi   = t[8] || (t[7:4] > 4'h9) || f[0];
        r    = t[7:0] + (hi ? 8'h60 : 8'h00);
        n[0] = hi;
      end
      default: r = a;
    endcase
    if (op >= 4'h4 && op <= 4'h9) n[2] = (r == 8'h00);
    return {r, r == 8'h00, n};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // drivers note each expectation before issuing the request
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    if (a == CSIL_FLAGS_ADDR) fl[3:0] = d[3:0];
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    rq.push_back(want);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
    logic [14:0] e;
    e  = alu_exp(op, a, b, fl);
    fl = e[5:0];
    aq.push_back(e);
    @(posedge clk);
    alu_valid <= 1'b1;
    alu_req   <= '{op: csil_alu_op_e'(op), a: a, b: b};
    @(posedge clk);
    alu_valid <= 1'b0;
  endtask

  // one-cycle pulse on the event lines
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    evs <= m;
    @(posedge clk);
    evs <= 8'h00;
  endtask

  // bounded wait for the expected acknowledges
  task automatic wait_q(input int n);
    for (int k = 0; k < 60 && iq.size() > n; k++) @(posedge clk);
    `CHK(iq.size() <= n, 1'b1)
  endtask

  task automatic stop_test();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // monitor: every result takes the oldest note; an unexpected ack meets an x
  always @(posedge clk) begin
    if (rd_q) begin
      e8 = rq.pop_front();
      `CHK(rdata, e8)
    end
    if (alu_rsp_valid) begin
      e15 = aq.pop_front();
      `CHK({alu_rsp.data, alu_rsp.skip, flags_view}, e15)
    end
    if (irq_ack) begin
      e8 = (iq.size() > 0) ? iq.pop_front() : 8'hxx;
      `CHK(bnd_q, 1'b1)
      `CHK(irq_vector, e8)
    end
    rd_q  <= rd;
    bnd_q <= instr_boundary;
  end

  // the run needs under a thousand cycles; this allows for far more
  initial begin
    #50000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    fl = 6'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(CSIL_FLAGS_ADDR, 8'h00);
    rd_reg(CSIL_IRQ_ADDR, 8'h00);
    rd_reg(8'h0c, 8'h00);
    wr_reg(CSIL_FLAGS_ADDR, 8'hff);
    rd_reg(CSIL_FLAGS_ADDR, 8'h0f);
    // sleep, timeout, software write, watchdog clear
    pulse(8'h01);
    rd_reg(CSIL_FLAGS_ADDR, 8'h1f);
    pulse(8'h04);
    rd_reg(CSIL_FLAGS_ADDR, 8'h3f);
    wr_reg(CSIL_FLAGS_ADDR, 8'h00);
    rd_reg(CSIL_FLAGS_ADDR, 8'h30);
    pulse(8'h02);
    fl[5:4] = 2'b00;
    rd_reg(CSIL_FLAGS_ADDR, 8'h00);
    // carry, borrow, bcd adjust, zero and, unused code, then random codes
    alu(4'h0, 8'hff, 8'h01);
    alu(4'h2, 8'h00, 8'h01);
    alu(4'h0, 8'h19, 8'h28);
    alu(4'he, 8'h41, 8'h00);
    alu(4'h4, 8'hf0, 8'h0f);
    alu(4'hf, 8'h5a, 8'h00);
    for (int i = 0; i < 60; i++) begin
      seed = xs(seed);
      alu(seed[3:0], seed[15:8], seed[23:16]);
    end
    rd_reg(CSIL_FLAGS_ADDR, {2'b00, fl});
    // three sources pending at once behind a cleared global enable
    gap <= 2'h3;
    wr_reg(CSIL_IRQ_ADDR, 8'h0e);
    pulse(8'h30);
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk);
    ext_pin <= 1'b1;
    #1;
    `CHK(wake_req, 1'b1)
    rd_reg(CSIL_IRQ_ADDR, 8'h7e);
    iq = '{CSIL_VEC_EXT, CSIL_VEC_TA, CSIL_VEC_TB};
    wr_reg(CSIL_IRQ_ADDR, 8'h7f);
    wait_q(2);
    rd_reg(CSIL_IRQ_ADDR, 8'h6e);
    rd_reg(CSIL_FLAGS_ADDR, {2'b00, fl});
    pulse(8'h08);
    wait_q(1);
    rd_reg(CSIL_IRQ_ADDR, 8'h4e);
    pulse(8'h08);
    wait_q(0);
    rd_reg(CSIL_IRQ_ADDR, 8'h0e);
    // full stack holds the request back until a return
    gap <= 2'h0;
    pulse(8'h80);
    repeat (8) pulse(8'h40);
    wr_reg(CSIL_IRQ_ADDR, 8'h05);
    pulse(8'h10);
    repeat (10) @(posedge clk);
    rd_reg(CSIL_IRQ_ADDR, 8'h25);
    iq.push_back(CSIL_VEC_TA);
    pulse(8'h80);
    wait_q(0);
    rd_reg(CSIL_IRQ_ADDR, 8'h04);
    `CHK(wake_req, 1'b0)
    // sleep and timeout together, then a reset in mid-run clears both
    pulse(8'h05);
    rd_reg(CSIL_FLAGS_ADDR, {4'h3, fl[3:0]});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    fl = 6'h00;
    rd_reg(CSIL_FLAGS_ADDR, 8'h00);
    rd_reg(CSIL_IRQ_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    `CHK(rq.size() + aq.size() + iq.size(), 0)
    stop_test();
  end
endmodule
